// *** include/pvl_pkg.sv ***
// Package of constants and types for the palette video lookup path.
`default_nettype none
package pvl_pkg;
  localparam int PVL_ENTRIES = 16;
  localparam int PVL_IDX_W = 4;
  localparam int PVL_CH_W = 4;
  localparam int PVL_ENTRY_W = 13;
  localparam int PVL_FIFO_DEPTH = 16;
  localparam int PVL_FIFO_W = PVL_IDX_W + 1;
  // Field positions inside one palette entry.
  localparam int PVL_CA_LSB = 0;
  localparam int PVL_CB_LSB = 4;
  localparam int PVL_CC_LSB = 8;
  localparam int PVL_MARK_BIT = 12;
  // Values after reset.
  localparam logic [PVL_ENTRY_W-1:0] PVL_ENTRY_RST = 13'h0000;
  localparam logic [PVL_CH_W-1:0] PVL_DARK = 4'h0;
  typedef logic [PVL_ENTRY_W-1:0] pvl_entry_t;
endpackage
`default_nettype wire

// *** hdl/pvl_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module pvl_fifo
#(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  fifo_full_stall_a: assert property (
    count == (AW+1)'(DEPTH) |-> !in_ready && !push)
    else $error("FIFO accepted data while full.");
  fifo_count_track_a: assert property (
    push && !pop |=> count == $past(count) + 1'b1)
    else $error("FIFO count did not follow a push.");
endmodule
`default_nettype wire

// *** hdl/pvl_lookup.sv ***
// Video side of the 16 entry colour palette: index capture and output.
`timescale 1ns/10ps
`default_nettype none
module pvl_lookup
  import pvl_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [PVL_IDX_W-1:0] pix_index,
  input wire logic blank_in,
  input wire logic select_high_in,
  input wire logic host_access_seen,
  input wire logic host_wr,
  input wire logic [PVL_IDX_W-1:0] host_index,
  input wire logic [PVL_ENTRY_W-1:0] host_wr_data,
  output logic [PVL_ENTRY_W-1:0] host_rd_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [PVL_CH_W-1:0] colour_a_out,
  output logic [PVL_CH_W-1:0] colour_b_out,
  output logic [PVL_CH_W-1:0] colour_c_out,
  output logic mark_out
);
  pvl_entry_t palette [PVL_ENTRIES];
  logic fifo_valid;
  logic [PVL_FIFO_W-1:0] fifo_data;
  logic advance;
  logic [PVL_IDX_W-1:0] colour_index;
  logic index_blank;
  logic index_valid;
  logic dark_hold;
  logic force_low;
  pvl_entry_t chosen;

  function automatic logic [PVL_CH_W-1:0] field(input pvl_entry_t e,
                                               input int lsb);
    field = e[lsb +: PVL_CH_W];
  endfunction

  pvl_fifo #(.WIDTH(PVL_FIFO_W), .DEPTH(PVL_FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data({blank_in, pix_index}),
    .out_valid(fifo_valid),
    .out_ready(advance),
    .out_data(fifo_data)
  );

  // The pipe moves whenever the output stage is empty or being drained.
  assign advance = out_ready || !out_valid;
  assign chosen = palette[colour_index];
  // While the pipe moves, forcing is decided at the edge that loads the output stage, so a host
  // access that starts in the middle of a word darkens the next word.
  assign force_low = index_blank || select_high_in || dark_hold;
  assign host_rd_data = palette[host_index];

  // Palette storage shared with host writes.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < PVL_ENTRIES; i++)
        palette[i] <= PVL_ENTRY_RST;
    end
    else if (host_wr)
    begin
      palette[host_index] <= host_wr_data;
    end
  end

  // Index and blank are latched together on the same edge. An empty FIFO
  // leaves the last index in place, so no unwritten storage is looked up.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      colour_index <= '0;
      index_blank <= 1'b0;
      index_valid <= 1'b0;
    end
    else if (advance)
    begin
      index_valid <= fifo_valid;
      if (fifo_valid)
      begin
        colour_index <= fifo_data[PVL_IDX_W-1:0];
        index_blank <= fifo_data[PVL_IDX_W];
      end
    end
  end

  // Darkness after reset lasts until the host touches the device.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      dark_hold <= 1'b1;
    else if (host_access_seen)
      dark_hold <= 1'b0;
  end

  // Output registers, loaded from the selected entry one period later.
  // A stall keeps the word, but select and dark hold still clear it.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      colour_a_out <= PVL_DARK;
      colour_b_out <= PVL_DARK;
      colour_c_out <= PVL_DARK;
      mark_out <= 1'b0;
      out_valid <= 1'b0;
    end
    else if (advance)
    begin
      out_valid <= index_valid;
      if (force_low)
      begin
        colour_a_out <= PVL_DARK;
        colour_b_out <= PVL_DARK;
        colour_c_out <= PVL_DARK;
        mark_out <= 1'b0;
      end
      else
      begin
        colour_a_out <= field(chosen, PVL_CA_LSB);
        colour_b_out <= field(chosen, PVL_CB_LSB);
        colour_c_out <= field(chosen, PVL_CC_LSB);
        mark_out <= chosen[PVL_MARK_BIT];
      end
    end
    else if (select_high_in || dark_hold)
    begin
      colour_a_out <= PVL_DARK;
      colour_b_out <= PVL_DARK;
      colour_c_out <= PVL_DARK;
      mark_out <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Checks on the video path and the host palette port; they are cut off while reset is low.
  index_capture_a: assert property (
    advance && fifo_valid |=>
      colour_index == $past(fifo_data[PVL_IDX_W-1:0]))
    else $error("Pixel index not captured.");
  blank_sample_a: assert property (
    advance && fifo_valid |=> index_blank == $past(fifo_data[PVL_IDX_W]))
    else $error("Blank not sampled with the index.");
  colour_follow_a: assert property (
    advance && !force_low |=>
      colour_a_out == $past(palette[colour_index][3:0]) &&
      colour_c_out == $past(palette[colour_index][11:8]))
    else $error("Colour output does not follow index.");
  mark_route_a: assert property (
    advance && !force_low |=>
      mark_out == $past(palette[colour_index][PVL_MARK_BIT]))
    else $error("Marking bit not routed.");
  blank_dark_a: assert property (
    advance && index_blank |=> colour_b_out == 4'h0 && !mark_out)
    else $error("Blanking did not force outputs low.");
  select_dark_a: assert property (
    select_high_in |=> colour_a_out == 4'h0 && colour_b_out == 4'h0 &&
      colour_c_out == 4'h0 && !mark_out)
    else $error("Chip select did not force outputs low.");
  reset_dark_a: assert property (
    dark_hold |=> colour_a_out == 4'h0 && !mark_out)
    else $error("Outputs not dark before first host access.");
  dark_release_a: assert property (
    host_access_seen |=> !dark_hold)
    else $error("Host access did not end the dark hold.");
  palette_write_a: assert property (
    host_wr |=> palette[$past(host_index)] == $past(host_wr_data))
    else $error("Palette entry not written.");
  palette_keep_a: assert property (
    !host_wr |=> palette[$past(host_index)] == $past(palette[host_index]))
    else $error("Palette entry changed without a write.");
  colour_b_a: assert property (
    advance && !force_low |=>
      colour_b_out == $past(palette[colour_index][7:4]))
    else $error("Middle colour channel not routed.");
  valid_stage_a: assert property (
    advance |=> index_valid == $past(fifo_valid))
    else $error("Index stage valid does not follow the FIFO.");
  valid_follow_a: assert property (
    advance |=> out_valid == $past(index_valid))
    else $error("Output valid does not follow the index stage.");
  output_hold_a: assert property (
    !advance && !select_high_in && !dark_hold |=>
      $stable(colour_a_out) && $stable(colour_c_out) && $stable(mark_out))
    else $error("Stalled output word changed.");
  stage_hold_a: assert property (
    !advance |=> $stable(colour_index) && $stable(index_valid))
    else $error("Index stage moved during a stall.");
  blank_zero_a: assert property (
    advance && index_blank |=> colour_a_out == 4'h0 && colour_c_out == 4'h0)
    else $error("Blanked word not all zero codes.");
  blank_valid_a: assert property (
    advance && index_valid && index_blank |=> out_valid && !mark_out)
    else $error("Blanked word not delivered as a dark word.");
  select_stall_a: assert property (
    !advance && select_high_in |=> colour_b_out == 4'h0 && !mark_out)
    else $error("Chip select did not darken a stalled word.");
  dark_keep_a: assert property (
    dark_hold && !host_access_seen |=> dark_hold)
    else $error("Dark hold ended without a host access.");
endmodule
`default_nettype wire

// *** tb/pvl_crt_model.sv ***
// Behavioural display timing source that offers pixel words.
`timescale 1ns/10ps
`default_nettype none
module pvl_crt_model
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic run,
  input wire logic pix_ready,
  output logic pix_valid,
  output logic [3:0] pix_index,
  output logic blank_in
);
  logic [4:0] n;
  logic [4:0] nx;
  logic took;
  logic hold;
  // Words 0 to 15 of each group of 32 are visible, the rest is retrace.
  assign nx = n + {4'h0, took};
  assign hold = run || (pix_valid && !took);
  always @(posedge mclk) took <= pix_valid && pix_ready;
  // An idle bus shows inverted values so stale data never looks valid.
  always @(negedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      n <= 5'h00;
      pix_valid <= 1'b0;
      pix_index <= 4'h0;
      blank_in <= 1'b0;
    end
    else
    begin
      n <= nx;
      pix_valid <= hold;
      pix_index <= hold ? nx[3:0] : ~pix_index;
      blank_in <= hold ? nx[4] : ~blank_in;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the palette video lookup path.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      err_total++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_top import pvl_pkg::*;;
  logic mclk = 1'b0, nrst = 1'b0, run = 1'b0, out_ready = 1'b1;
  logic select_high_in = 1'b0, host_access_seen = 1'b0, host_wr = 1'b0;
  logic sel_d = 1'b0, dark_exp = 1'b1;
  logic [PVL_IDX_W-1:0] host_index = 4'h0;
  pvl_entry_t host_wr_data = 13'h0000;
  pvl_entry_t host_rd_data, got;
  logic pix_valid, pix_ready, blank_in, out_valid, mark_out;
  logic [PVL_IDX_W-1:0] pix_index;
  logic [PVL_CH_W-1:0] colour_a_out, colour_b_out, colour_c_out;
  int err_total = 0, samples_checked = 0, k = 0, taken = 0, zap_k = -1;

  function automatic pvl_entry_t ent(input logic [3:0] i);
    return {i[0], i ^ 4'h5, i, ~i};
  endfunction

  pvl_lookup dut (.mclk(mclk), .nrst(nrst), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_index(pix_index), .blank_in(blank_in),
    .select_high_in(select_high_in), .host_access_seen(host_access_seen),
    .host_wr(host_wr), .host_index(host_index), .host_wr_data(host_wr_data),
    .host_rd_data(host_rd_data), .out_valid(out_valid), .out_ready(out_ready),
    .colour_a_out(colour_a_out), .colour_b_out(colour_b_out),
    .colour_c_out(colour_c_out), .mark_out(mark_out));
  pvl_crt_model src (.mclk(mclk), .nrst(nrst), .run(run),
    .pix_ready(pix_ready), .pix_valid(pix_valid), .pix_index(pix_index),
    .blank_in(blank_in));

  initial forever #5 mclk = ~mclk;

  // Every consumed word is judged in stream order against its source word.
  always @(posedge mclk)
  begin
    sel_d <= select_high_in;
    if (nrst && pix_valid && pix_ready) taken++;
    if (nrst && out_valid === 1'b1 && out_ready)
    begin
      if (dark_exp || sel_d || k[4] || k == zap_k)
        got = 13'h0000;
      else
        got = ent(k[3:0]);
      `CHK("colour_a", got[3:0], colour_a_out)
      `CHK("colour_b", got[7:4], colour_b_out)
      `CHK("colour_c", got[11:8], colour_c_out)
      `CHK("mark", got[12], mark_out)
      if (dark_exp || sel_d)
        `CHK("forced", 4'h0, colour_b_out)
      k++;
    end
  end

  task automatic tick(int c);
    repeat (c) @(negedge mclk);
  endtask

  task automatic drain;
    run <= 1'b0;
    repeat (100) if (k != taken || pix_valid) @(negedge mclk);
    `CHK("drained", taken, k)
  endtask

  task automatic t_dark;
    run <= 1'b1;
    tick(40);
    drain;
  endtask

  task automatic t_load;
    for (int i = 0; i < PVL_ENTRIES; i++)
    begin
      host_wr <= 1'b1;
      host_index <= i[3:0];
      host_wr_data <= ent(i[3:0]);
      tick(1);
    end
    host_wr <= 1'b0;
    for (int i = 0; i < PVL_ENTRIES; i++)
    begin
      host_index <= i[3:0];
      tick(1);
      `CHK("readback", ent(i[3:0]), host_rd_data)
    end
    host_access_seen <= 1'b1;
    tick(1);
    host_access_seen <= 1'b0;
    tick(1);
    dark_exp = 1'b0;
  endtask

  task automatic t_stall;
    out_ready <= 1'b0;
    run <= 1'b1;
    tick(40);
    `CHK("refused", 1'b0, pix_ready)
    // The stalled word is word k; a select pulse must darken it in place.
    zap_k = k;
    select_high_in <= 1'b1;
    tick(1);
    select_high_in <= 1'b0;
    tick(1);
    `CHK("held_dark", 4'h0, colour_a_out)
    `CHK("held_mark", 1'b0, mark_out)
    out_ready <= 1'b1;
    tick(40);
    drain;
  endtask

  task automatic t_select;
    run <= 1'b1;
    tick(10);
    select_high_in <= 1'b1;
    tick(5);
    select_high_in <= 1'b0;
    tick(20);
    drain;
  endtask

  task automatic close_out;
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    tick(5);
    nrst <= 1'b1;
    tick(1);
    t_dark;
    t_load;
    t_stall;
    t_select;
    close_out;
  end

  initial
  begin
    #20000;
    err_total++;
    close_out;
  end
endmodule
`default_nettype wire
